// ==== bfe_map.svh ====
`ifndef BFE_MAP_SVH
`define BFE_MAP_SVH

// Geometry of each queue
`define BFE_W 36
`define BFE_DEPTH 128
`define BFE_PW 7
`define BFE_CW 8
`define BFE_DEPTH_CNT 8'h80

// Register byte offsets
`define BFE_REG_PAE 8'h00
`define BFE_REG_PBE 8'h04
`define BFE_REG_PAF 8'h08
`define BFE_REG_PBF 8'h0C
`define BFE_REG_STAT 8'h10

// Status field positions
`define BFE_ST_CAB_LSB 0
`define BFE_ST_CBA_LSB 8
`define BFE_ST_BE_BIT 16
`define BFE_ST_FIRST_WORD_FALLTHROUGH_MODE_BIT 17
`define BFE_ST_SIZE_LSB 18

// Default offset select codes and values
`define BFE_FS_8 2'h0
`define BFE_FS_16 2'h1
`define BFE_FS_64 2'h2
`define BFE_OFF_8 8'h08
`define BFE_OFF_16 8'h10
`define BFE_OFF_64 8'h40

// Lane positions on the 36-bit word
`define BFE_LANE1 6'h09
`define BFE_LANE2 6'h12
`define BFE_LANE3 6'h1B
`define BFE_MASK_HALF 36'h0_0003_FFFF
`define BFE_MASK_BYTE 36'h0_0000_01FF

`endif

// ==== bfe_pkg.sv ====
package bfe_pkg;
`include "bfe_map.svh"

	typedef logic [`BFE_W-1:0] bfe_word_t;
	typedef logic [`BFE_PW-1:0] bfe_ptr_t;
	typedef logic [`BFE_CW-1:0] bfe_cnt_t;

	typedef enum logic [1:0] {BFE_SZ_LONG, BFE_SZ_HALF, BFE_SZ_BYTE} bfe_size_e;

	typedef struct packed {
		bfe_word_t a_bus;
		logic a_wr;
		logic a_rd;
		logic a_drv;
		bfe_word_t b_bus;
		logic b_wr;
		logic b_rd;
		logic b_drv;
		logic sel;
		logic [1:0] fs;
		logic bm;
		logic sz;
	} bfe_pins_s;

	typedef struct packed {
		bfe_pins_s sync1;
		bfe_pins_s sync2;
		logic big_endian;
		logic first_word_fallthrough_mode;
		bfe_size_e size;
		bfe_word_t [`BFE_DEPTH-1:0] mem_ab;
		bfe_word_t [`BFE_DEPTH-1:0] mem_ba;
		bfe_ptr_t wp_ab;
		bfe_ptr_t rp_ab;
		bfe_ptr_t wp_ba;
		bfe_ptr_t rp_ba;
		bfe_cnt_t cnt_ab;
		bfe_cnt_t cnt_ba;
		bfe_word_t a_out;
		logic a_out_v;
		bfe_word_t b_out;
		logic b_out_v;
		logic [1:0] b_piece;
		bfe_word_t b_asm;
		logic [1:0] b_asm_n;
		bfe_cnt_t pae;
		bfe_cnt_t pbe;
		bfe_cnt_t paf;
		bfe_cnt_t pbf;
		logic ae_a_n;
		logic ae_b_n;
		logic af_a_n;
		logic af_b_n;
		bfe_word_t a_pin;
		bfe_word_t b_pin;
		logic a_oe_n;
		logic b_oe_n;
		logic ack;
		logic [31:0] dat;
	} bfe_top_s;

	typedef struct packed {
		bfe_word_t e0;
		bfe_word_t e1;
		logic [1:0] cnt;
		logic in_ready;
	} bfe_skid_s;

endpackage : bfe_pkg

// ==== bfe_skid.sv ====
`timescale 1ns/10ps
module bfe_skid
	import bfe_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	input wire bfe_word_t in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output bfe_word_t out_data_o,
	input wire logic out_ready_i
);
	bfe_skid_s st;
	bfe_skid_s nxt;
	logic push;
	logic pop;

	always_comb
	begin
		nxt = st;
		push = in_valid_i && st.in_ready;
		pop = (st.cnt != 2'h0) && out_ready_i;
		if (rst_i)
		begin
			nxt = '0;
		end
		else
		begin
			if (pop)
			begin
				nxt.e0 = st.e1;
				nxt.cnt = st.cnt - 2'h1;
			end
			if (push)
			begin
				if (nxt.cnt == 2'h0)
					nxt.e0 = in_data_i;
				else
					nxt.e1 = in_data_i;
				nxt.cnt = nxt.cnt + 2'h1;
			end
		end
		// Ready drops only when both slots hold a word
		nxt.in_ready = (nxt.cnt != 2'h2);
	end

	always_ff @(posedge clk_i)
	begin
		if (ce_i)
			st <= nxt;
	end

	assign in_ready_o = st.in_ready;
	assign out_valid_o = (st.cnt != 2'h0);
	assign out_data_o = st.e0;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_SKID_HOLDS:
	assert property (ce_i && st.cnt == 2'h2 && !out_ready_i |=> st.cnt == 2'h2 && !in_ready_o)
	else $error("buffer lost a stored word");

endmodule : bfe_skid

// ==== bfe_top.sv ====
`timescale 1ns/10ps
// Behaviour
// - Port A 36-bit two-way data bus
// - Port B 36-bit two-way data bus
// - Port A almost-empty low at B-to-A count<=offset
// - Port B almost-empty low at A-to-B count<=offset
// - Port A almost-full low when A-to-B free<=offset
// - Port B almost-full low when B-to-A free<=offset
// - Select pin at reset picks endian order
// - Big endian: A word's top piece first
// - Big endian: first B piece goes top
// - Little endian: A word's low piece first
// - Little endian: first B piece goes low
// - After reset select pin picks timing mode
// - Fall-through shows first word without read
// - Reset picks default offsets 8, 16, 64
// - Flags assert exactly at programmed value
module bfe_top
	import bfe_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire bfe_word_t port_a_bus_i,
	output bfe_word_t port_a_bus_o,
	output logic port_a_bus_oe_n_o,
	input wire logic port_a_write_i,
	input wire logic port_a_read_i,
	input wire logic port_a_drive_i,
	output logic port_a_write_ready_o,
	input wire bfe_word_t port_b_bus_i,
	output bfe_word_t port_b_bus_o,
	output logic port_b_bus_oe_n_o,
	input wire logic port_b_write_i,
	input wire logic port_b_read_i,
	input wire logic port_b_drive_i,
	input wire logic endian_timing_select_i,
	input wire logic [1:0] flag_select_i,
	input wire logic bus_match_i,
	input wire logic bus_size_i,
	output logic port_a_almost_empty_n_o,
	output logic port_b_almost_empty_n_o,
	output logic port_a_almost_full_n_o,
	output logic port_b_almost_full_n_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	bfe_top_s st;
	bfe_top_s nxt;
	bfe_pins_s pins;
	logic skid_valid;
	logic skid_ready;
	bfe_word_t skid_data;
	logic ab_push;
	logic ab_pop;
	logic ba_push;
	logic ba_pop;
	logic b_adv;
	logic b_need;
	logic a_adv;
	logic [31:0] rd_data;

	function automatic logic [1:0] last_piece(input bfe_size_e s);
		case (s)
			BFE_SZ_HALF: return 2'h1;
			BFE_SZ_BYTE: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction : last_piece

	function automatic logic [5:0] piece_lsb(input logic [1:0] k, input bfe_size_e s,
		input logic be);
		logic [1:0] pos;
		pos = be ? (last_piece(s) - k) : k;
		case (s)
			BFE_SZ_HALF: return pos[0] ? `BFE_LANE2 : 6'h00;
			BFE_SZ_BYTE:
				case (pos)
					2'h1: return `BFE_LANE1;
					2'h2: return `BFE_LANE2;
					2'h3: return `BFE_LANE3;
					default: return 6'h00;
				endcase
			default: return 6'h00;
		endcase
	endfunction : piece_lsb

	function automatic bfe_word_t piece_mask(input bfe_size_e s);
		case (s)
			BFE_SZ_HALF: return `BFE_MASK_HALF;
			BFE_SZ_BYTE: return `BFE_MASK_BYTE;
			default: return '1;
		endcase
	endfunction : piece_mask

	function automatic bfe_cnt_t count_free(input bfe_cnt_t c);
		return `BFE_DEPTH_CNT - c;
	endfunction : count_free

	function automatic bfe_cnt_t default_off(input logic [1:0] fs);
		case (fs)
			`BFE_FS_16: return `BFE_OFF_16;
			`BFE_FS_64: return `BFE_OFF_64;
			default: return `BFE_OFF_8;
		endcase
	endfunction : default_off

	// A-to-B writes pass a two-entry buffer; once a full queue fills it, ready drops and later writes are lost
	bfe_skid u_skid (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(st.sync2.a_wr),
		.in_data_i(st.sync2.a_bus),
		.in_ready_o(port_a_write_ready_o),
		.out_valid_o(skid_valid),
		.out_data_o(skid_data),
		.out_ready_i(skid_ready)
	);

	always_comb
	begin
		pins.a_bus = port_a_bus_i;
		pins.a_wr = port_a_write_i;
		pins.a_rd = port_a_read_i;
		pins.a_drv = port_a_drive_i;
		pins.b_bus = port_b_bus_i;
		pins.b_wr = port_b_write_i;
		pins.b_rd = port_b_read_i;
		pins.b_drv = port_b_drive_i;
		pins.sel = endian_timing_select_i;
		pins.fs = flag_select_i;
		pins.bm = bus_match_i;
		pins.sz = bus_size_i;
	end

	assign skid_ready = (st.cnt_ab != `BFE_DEPTH_CNT) && !rst_i;

	always_comb
	begin
		nxt = st;
		nxt.sync1 = pins;
		nxt.sync2 = st.sync1;
		ab_push = 1'b0;
		ab_pop = 1'b0;
		ba_push = 1'b0;
		ba_pop = 1'b0;
		b_adv = 1'b0;
		b_need = 1'b0;
		a_adv = 1'b0;
		rd_data = 32'h0000_0000;
		if (rst_i)
		begin
			nxt = '0;
			nxt.sync1 = pins;
			nxt.sync2 = st.sync1;
			nxt.big_endian = st.sync2.sel;
			nxt.size = !st.sync2.bm ? BFE_SZ_LONG : (st.sync2.sz ? BFE_SZ_BYTE : BFE_SZ_HALF);
			nxt.pae = default_off(st.sync2.fs);
			nxt.pbe = default_off(st.sync2.fs);
			nxt.paf = default_off(st.sync2.fs);
			nxt.pbf = default_off(st.sync2.fs);
			nxt.af_a_n = 1'b1;
			nxt.af_b_n = 1'b1;
			nxt.a_oe_n = 1'b1;
			nxt.b_oe_n = 1'b1;
		end
		else
		begin
			// Pin is assumed static while running, so no glitch guard
			nxt.first_word_fallthrough_mode = ~st.sync2.sel;
			ab_push = skid_valid && skid_ready;
			if (ab_push)
			begin
				nxt.mem_ab[st.wp_ab] = skid_data;
				nxt.wp_ab = st.wp_ab + 7'h01;
			end
			// Port B read: one stored word is split into narrow pieces
			b_adv = st.sync2.b_rd && st.b_out_v;
			b_need = !st.b_out_v || (b_adv && st.b_piece == last_piece(st.size));
			if (b_adv && !b_need)
				nxt.b_piece = st.b_piece + 2'h1;
			if (b_need)
			begin
				if ((st.first_word_fallthrough_mode || st.sync2.b_rd) && st.cnt_ab != 8'h00)
				begin
					nxt.b_out = st.mem_ab[st.rp_ab];
					nxt.rp_ab = st.rp_ab + 7'h01;
					nxt.b_out_v = 1'b1;
					nxt.b_piece = 2'h0;
					ab_pop = 1'b1;
				end
				else if (b_adv)
					nxt.b_out_v = 1'b0;
			end
			// Port B write: pieces gather into one word before the queue sees it
			if (st.sync2.b_wr)
			begin
				nxt.b_asm = ((st.b_asm_n == 2'h0) ? '0 : st.b_asm)
					| ((st.sync2.b_bus & piece_mask(st.size))
					<< piece_lsb(st.b_asm_n, st.size, st.big_endian));
				if (st.b_asm_n == last_piece(st.size))
				begin
					nxt.b_asm_n = 2'h0;
					// Word completed into a full queue is dropped
					if (st.cnt_ba != `BFE_DEPTH_CNT)
					begin
						ba_push = 1'b1;
						nxt.mem_ba[st.wp_ba] = nxt.b_asm;
						nxt.wp_ba = st.wp_ba + 7'h01;
					end
				end
				else
					nxt.b_asm_n = st.b_asm_n + 2'h1;
			end
			// Port A read: whole words only
			a_adv = st.sync2.a_rd && st.a_out_v;
			if (!st.a_out_v || a_adv)
			begin
				if ((st.first_word_fallthrough_mode || st.sync2.a_rd) && st.cnt_ba != 8'h00)
				begin
					nxt.a_out = st.mem_ba[st.rp_ba];
					nxt.rp_ba = st.rp_ba + 7'h01;
					nxt.a_out_v = 1'b1;
					ba_pop = 1'b1;
				end
				else if (a_adv)
					nxt.a_out_v = 1'b0;
			end
			nxt.cnt_ab = st.cnt_ab + {7'h00, ab_push} - {7'h00, ab_pop};
			nxt.cnt_ba = st.cnt_ba + {7'h00, ba_push} - {7'h00, ba_pop};
			nxt.a_oe_n = ~st.sync2.a_drv;
			nxt.b_oe_n = ~st.sync2.b_drv;
			// Wishbone slave, one wait state, unmapped reads zero
			nxt.ack = wb_cyc_i && wb_stb_i && !st.ack;
			case (wb_adr_i)
				`BFE_REG_PAE: rd_data[7:0] = st.pae;
				`BFE_REG_PBE: rd_data[7:0] = st.pbe;
				`BFE_REG_PAF: rd_data[7:0] = st.paf;
				`BFE_REG_PBF: rd_data[7:0] = st.pbf;
				`BFE_REG_STAT:
				begin
					rd_data[`BFE_ST_CAB_LSB +: 8] = st.cnt_ab;
					rd_data[`BFE_ST_CBA_LSB +: 8] = st.cnt_ba;
					rd_data[`BFE_ST_BE_BIT] = st.big_endian;
					rd_data[`BFE_ST_FIRST_WORD_FALLTHROUGH_MODE_BIT] = st.first_word_fallthrough_mode;
					rd_data[`BFE_ST_SIZE_LSB +: 2] = st.size;
				end
				default: rd_data = 32'h0000_0000;
			endcase
			nxt.dat = (nxt.ack && !wb_we_i) ? rd_data : 32'h0000_0000;
			if (nxt.ack && wb_we_i && wb_sel_i[0])
			begin
				case (wb_adr_i)
					`BFE_REG_PAE: nxt.pae = wb_dat_i[7:0];
					`BFE_REG_PBE: nxt.pbe = wb_dat_i[7:0];
					`BFE_REG_PAF: nxt.paf = wb_dat_i[7:0];
					`BFE_REG_PBF: nxt.pbf = wb_dat_i[7:0];
					default: nxt.dat = 32'h0000_0000;
				endcase
			end
			// Flags come from next-state counts, so assertion is exact
			nxt.ae_a_n = !(nxt.cnt_ba <= nxt.pae);
			nxt.ae_b_n = !(nxt.cnt_ab <= nxt.pbe);
			nxt.af_a_n = !(count_free(nxt.cnt_ab) <= nxt.paf);
			nxt.af_b_n = !(count_free(nxt.cnt_ba) <= nxt.pbf);
		end
		nxt.a_pin = nxt.a_out;
		// Narrow pieces sit on the low lanes of port B
		nxt.b_pin = (nxt.b_out >> piece_lsb(nxt.b_piece, nxt.size, nxt.big_endian))
			& piece_mask(nxt.size);
	end

	always_ff @(posedge clk_i)
	begin
		if (ce_i)
			st <= nxt;
	end

	assign port_a_bus_o = st.a_pin;
	assign port_a_bus_oe_n_o = st.a_oe_n;
	assign port_b_bus_o = st.b_pin;
	assign port_b_bus_oe_n_o = st.b_oe_n;
	assign port_a_almost_empty_n_o = st.ae_a_n;
	assign port_b_almost_empty_n_o = st.ae_b_n;
	assign port_a_almost_full_n_o = st.af_a_n;
	assign port_b_almost_full_n_o = st.af_b_n;
	assign wb_dat_o = st.dat;
	assign wb_ack_o = st.ack;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_drive_req(logic d);
		ce_i && st.sync1.a_drv == d ##1 ce_i;
	endsequence

	sequence s_ab_push_only;
		ce_i && ab_push && !ab_pop;
	endsequence

	AST_A_DRIVE:
	assert property (s_drive_req(1'b1) |=> port_a_bus_oe_n_o == 1'b0)
	else $error("port A not driven after drive request");

	AST_B_DRIVE:
	assert property (ce_i && st.sync2.b_drv |=> !port_b_bus_oe_n_o)
	else $error("port B not driven after drive request");

	AST_AE_A:
	assert property (st.cnt_ba <= st.pae && $past(ce_i) |-> !port_a_almost_empty_n_o)
	else $error("port A almost-empty missing");

	AST_AE_B:
	assert property (port_b_almost_empty_n_o |-> st.cnt_ab > st.pbe)
	else $error("port B almost-empty high too early");

	AST_AF_A:
	assert property (count_free(st.cnt_ab) <= st.paf |-> !port_a_almost_full_n_o)
	else $error("port A almost-full missing");

	AST_AF_B:
	assert property (!port_b_almost_full_n_o |-> count_free(st.cnt_ba) <= st.pbf)
	else $error("port B almost-full low without cause");

	AST_ENDIAN_HELD:
	assert property (ce_i && !rst_i |=> st.big_endian == $past(st.big_endian))
	else $error("endian order changed while running");

	AST_BIG_FIRST:
	assert property (st.b_out_v && st.b_piece == 2'h0 && st.big_endian
		&& st.size == BFE_SZ_BYTE |-> port_b_bus_o[8:0] == st.b_out[35:27])
	else $error("big endian did not send top byte first");

	AST_LITTLE_FIRST:
	assert property (st.b_out_v && st.b_piece == 2'h0 && !st.big_endian
		&& st.size == BFE_SZ_HALF |-> port_b_bus_o[17:0] == st.b_out[17:0])
	else $error("little endian did not send low half first");

	AST_FALLTHROUGH:
	assert property (ce_i && st.first_word_fallthrough_mode && !st.a_out_v && st.cnt_ba != 8'h00
		|=> st.a_out_v ##0 port_a_bus_o == $past(st.mem_ba[st.rp_ba]))
	else $error("first word did not fall through");

	AST_DEFAULT_OFF:
	assert property ($fell(rst_i) |-> st.pae == st.pbf && st.paf == st.pbe
		&& (st.pae == `BFE_OFF_8 || st.pae == `BFE_OFF_16 || st.pae == `BFE_OFF_64))
	else $error("default offset not loaded at reset");

	AST_COUNT_UP:
	assert property (s_ab_push_only |=> st.cnt_ab == $past(st.cnt_ab) + 8'h01)
	else $error("A-to-B count did not follow a write");

endmodule : bfe_top

// ==== bfe_host.sv ====
`timescale 1ns/10ps
// Far-side master for one port; pins change only just after a rising edge
module bfe_host
	import bfe_pkg::*;
(
	input wire logic clk_i,
	input wire bfe_word_t dev_bus_i,
	input wire logic dev_oe_n_i,
	output bfe_word_t bus_o,
	output logic write_o,
	output logic read_o,
	output logic drive_o
);
	bfe_word_t val_r;
	logic own_r;

	// Released wire shows the inverse of the last value, so stale data never matches
	assign bus_o = !dev_oe_n_i ? dev_bus_i : (own_r ? val_r : ~val_r);

	initial
	begin
		val_r = '0;
		own_r = 1'h0;
		write_o = 1'h0;
		read_o = 1'h0;
		drive_o = 1'h0;
	end

	task put(input bfe_word_t x);
		@(posedge clk_i);
		write_o <= 1'h1;
		val_r <= x;
		own_r <= 1'h1;
	endtask : put

	task idle();
		@(posedge clk_i);
		write_o <= 1'h0;
		own_r <= 1'h0;
		repeat (8) @(posedge clk_i);
	endtask : idle

	// Eight cycles cover the pin synchronisers and the output register
	task step();
		@(posedge clk_i);
		read_o <= 1'h1;
		@(posedge clk_i);
		read_o <= 1'h0;
		repeat (8) @(posedge clk_i);
	endtask : step

	task drive(input logic on);
		@(posedge clk_i);
		drive_o <= on;
		repeat (8) @(posedge clk_i);
	endtask : drive
endmodule : bfe_host

// ==== test_bidir_fifo_flags_endian_select.sv ====
`timescale 1ns/10ps
module test_bidir_fifo_flags_endian_select
	import bfe_pkg::*;
;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1, sel_pin = 1'h1, bm = 1'h0, sz = 1'h0;
	logic [1:0] fs = 2'h0;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
	logic ce = 1'h1;
	logic [3:0] wsel = 4'hF;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, wbq, rdat;
	bfe_word_t a_in, a_out, b_in, b_out, w;
	logic a_oe_n, b_oe_n, a_wr, a_rd, a_dv, b_wr, b_rd, b_dv, rdy;
	logic ae_a_n, ae_b_n, af_a_n, af_b_n;
	int n_fail = 0, checked = 0, cycles = 0, be, fw, np, pw, wb_n;
	logic [31:0] lf = 32'h2366;
	bfe_word_t q_ab[$], q_ba[$];

	bfe_top bfe_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.port_a_bus_i(a_in), .port_a_bus_o(a_out), .port_a_bus_oe_n_o(a_oe_n),
		.port_a_write_i(a_wr), .port_a_read_i(a_rd), .port_a_drive_i(a_dv),
		.port_a_write_ready_o(rdy), .port_b_bus_i(b_in), .port_b_bus_o(b_out),
		.port_b_bus_oe_n_o(b_oe_n), .port_b_write_i(b_wr), .port_b_read_i(b_rd),
		.port_b_drive_i(b_dv), .endian_timing_select_i(sel_pin), .flag_select_i(fs),
		.bus_match_i(bm), .bus_size_i(sz), .port_a_almost_empty_n_o(ae_a_n),
		.port_b_almost_empty_n_o(ae_b_n), .port_a_almost_full_n_o(af_a_n),
		.port_b_almost_full_n_o(af_b_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(wbq), .wb_ack_o(ack));
	bfe_host host_a (.clk_i(clk_i), .dev_bus_i(a_out), .dev_oe_n_i(a_oe_n), .bus_o(a_in),
		.write_o(a_wr), .read_o(a_rd), .drive_o(a_dv));
	bfe_host host_b (.clk_i(clk_i), .dev_bus_i(b_out), .dev_oe_n_i(b_oe_n), .bus_o(b_in),
		.write_o(b_wr), .read_o(b_rd), .drive_o(b_dv));

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Lane of the k-th narrow piece of a 36-bit word
	function automatic bfe_word_t piece(input bfe_word_t x, input int k);
		int lane;
		lane = be ? np - 1 - k : k;
		return (x >> (lane * pw)) & ((pw == 36) ? '1 : ((36'h1 << pw) - 36'h1));
	endfunction : piece

	task rnd();
		lf = lfsr(lf);
		w = {lf[3:0] ^ lf[31:28], lf};
	endtask : rnd

	task chk(input bfe_word_t got, input bfe_word_t exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Waits for ack however long it takes; only the cycle ceiling ends a hang
	task wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w_en;
		adr <= a;
		wdat <= d;
		wb_n = 0;
		do
		begin
			@(posedge clk_i);
			wb_n++;
		end
		while (ack !== 1'h1);
		rdat = wbq;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask : wb

	task flags(input int cab, input int cba);
		chk(ae_b_n, cab > 2);
		chk(af_a_n, (128 - cab) > 125);
		chk(ae_a_n, cba > 0);
		chk(af_b_n, (128 - cba) > 127);
		wb(1'h0, 8'h10, 32'h0);
		chk(rdat[15:0], {8'(cba), 8'(cab)});
	endtask : flags

	task wrap_up();
		$display("Compares %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			$display("Error at %0t: cycle ceiling reached", $time);
			wrap_up();
		end
	end

	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			be = (i % 2 == 0);
			fw = (i == 0 || i == 3);
			np = (i == 0) ? 1 : (i == 1) ? 2 : 4;
			pw = 36 / np;
			@(posedge clk_i);
			sel_pin <= be[0];
			fs <= 2'(i);
			bm <= (i > 0);
			sz <= (i > 1);
			@(posedge clk_i);
			rst_i <= 1'h1;
			repeat (5) @(posedge clk_i);
			rst_i <= 1'h0;
			sel_pin <= !fw[0];
			repeat (5) @(posedge clk_i);
			wb(1'h0, 8'h10, 32'h0);
			chk(rdat[19:16], {2'(np == 4 ? 2 : np - 1), fw[0], be[0]});
			wb(1'h0, 8'h00, 32'h0);
			chk(rdat, (i == 1) ? 16 : (i == 2) ? 64 : 8);
			wb(1'h0, 8'h14, 32'h0);
			chk(rdat, 0);
			wb(1'h1, 8'h04, 32'h2);
			wb(1'h1, 8'h00, 32'h0);
			wb(1'h1, 8'h08, 32'h7D);
			wb(1'h1, 8'h0C, 32'h7F);
			// Byte lane 0 disabled: the offset write must be ignored
			wsel <= 4'hE;
			wb(1'h1, 8'h08, 32'h33);
			wsel <= 4'hF;
			// Clock enable low stalls the bus answer by the frozen cycles
			fork
				wb(1'h0, 8'h08, 32'h0);
				begin
					ce <= 1'h0;
					repeat (4) @(posedge clk_i);
					ce <= 1'h1;
				end
			join
			chk(wb_n, 5);
			chk(rdat, 32'h7D);
			q_ab.delete();
			q_ba.delete();
			for (int j = 0; j < 3; j++)
			begin
				rnd();
				q_ab.push_back(w);
				host_a.put(w);
				host_a.idle();
				// Fall-through pulls the head out of the count, so counts only in standard mode
				if (!fw)
					flags(j + 1, 0);
			end
			if (i == 2)
			begin
				// Back-to-back until refused: queue plus two buffer entries survive
				for (int j = 0; j < 132; j++)
				begin
					rnd();
					if (q_ab.size() < 130)
						q_ab.push_back(w);
					host_a.put(w);
				end
				host_a.idle();
				chk(rdy, 1'h0);
				flags(128, 0);
			end
			host_b.drive(1'h1);
			for (int j = 0; j < q_ab.size(); j++)
			begin
				if (j == 0 && !fw)
					host_b.step();
				for (int k = 0; k < np; k++)
				begin
					chk(b_oe_n, 1'h0);
					chk(b_out, piece(q_ab[j], k));
					host_b.step();
				end
			end
			host_b.drive(1'h0);
			for (int j = 0; j < 2; j++)
			begin
				rnd();
				q_ba.push_back(w);
				for (int k = 0; k < np; k++)
					host_b.put(piece(w, k));
				host_b.idle();
				if (!fw && j == 0)
					flags(0, 1);
			end
			host_a.drive(1'h1);
			for (int j = 0; j < 2; j++)
			begin
				if (j == 0 && !fw)
					host_a.step();
				chk(a_oe_n, 1'h0);
				chk(a_out, q_ba[j]);
				host_a.step();
			end
			host_a.drive(1'h0);
		end
		wrap_up();
	end
endmodule : test_bidir_fifo_flags_endian_select
